// [datapath_cfg.svh]
// Offsets, field positions, reset values and counts of the shift-left product datapath.
`ifndef DATAPATH_CFG_SVH
`define DATAPATH_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD 8'h00
`define OFF_SHIFT 8'h04
`define OFF_STATUS 8'h08
`define OFF_PRODHI 8'h0C
`define OFF_STRLEN 8'h10
`define OFF_ADDRPTR 8'h14
`define OFF_ADDRSTEP 8'h18
`define OFF_OPERAND2 8'h1C
`define OFF_PC 8'h20
`define OFF_ACCPTR 8'h24
`define OFF_REPEAT 8'h28
`define REGION_ACC 2'b01
`define REGION_MEM 2'b10

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define ST_XM_BIT 0
`define ST_OF_BIT 1
`define ST_SF_BIT 2
`define ST_ZF_BIT 3
`define ST_CF_BIT 4
`define ST_TAG_BIT 5
`define ST_BUSY_BIT 8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_NIBBLE 4'h0
`define RST_WORD16 16'h0000
`define RST_WORD17 17'h0_0000
`define ACC_OFFSET 4'h8
`define ADDR_POST_INC 16'h0002
`define STR_EXTRA_NORMAL 5'h01
`define STR_EXTRA_REPEAT 5'h02

`endif

// [datapath_pkg.sv]
// Types shared by the shift-left product datapath files.
package datapath_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PREP = 4'b0010,
        ST_RUN = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;

    typedef enum logic [1:0] {
        OP_TO_PRODUCT = 2'h0,
        OP_SUB_LOW = 2'h1,
        OP_STR_SUB_LOW = 2'h2,
        OP_STR_ADD_LOW = 2'h3
    } opcode_t;

    typedef enum logic [1:0] {
        MOD_NONE = 2'h0,
        MOD_PRE_INC = 2'h1,
        MOD_PRE_DEC = 2'h2,
        MOD_SPARE = 2'h3
    } ptr_mod_t;

    typedef enum logic [1:0] {
        ADR_INDIRECT = 2'h0,
        ADR_POST_INC = 2'h1,
        ADR_PLUS_STEP = 2'h2,
        ADR_DIRECT = 2'h3
    } addr_mode_t;

    typedef struct packed {
        logic [5:0] spare;
        logic repeatPrefix;
        addr_mode_t addrMode;
        ptr_mod_t modifier;
        logic dstOffset;
        logic srcOffset;
        logic srcMemory;
        opcode_t op;
    } command_t;

    typedef struct packed {
        logic tag;
        logic carryFlag;
        logic zeroFlag;
        logic signFlag;
        logic overflowFlag;
    } flags_t;

endpackage

// [shift_word_unit.sv]
// One 16-bit slice of the left shifter with carry-in of bits shifted out below.
`timescale 1ns/100ps

module shift_word_unit (
    input wire logic [15:0] wordIn,
    input wire logic [15:0] carryIn,
    input wire logic [3:0] shiftAmt,
    input wire logic signFill,
    output logic [15:0] lowOut,
    output logic [15:0] carryOut
);
    logic [31:0] extended;
    logic [31:0] shifted;

    // RL2 left fill select
    assign extended = {(signFill ? {16{wordIn[15]}} : 16'h0000), wordIn};
    // RL8 zeros enter right
    assign shifted = extended << shiftAmt;
    assign lowOut = shifted[15:0] | carryIn;
    assign carryOut = shifted[31:16];
endmodule

// [shift_left_product_datapath.sv]
// Shift-left product datapath with APB register access.
// Operation
// RL1 - String shift to product shifts the string left by the shift value.
// RL2 - Left fill is zeros or sign copies per extended sign mode.
// RL3 - String shift to product latches upper word into product high.
// RL4 - String shift to product leaves all source accumulators unchanged.
// RL5 - Under repeat prefix the string length is the register plus two.
// RL6 - String shift to product updates overflow, sign, zero and carry flags.
// RL7 - Shift with subtract adjusts the accumulator pointer before shifting.
// RL8 - Shift with subtract forms a 32-bit result with zeros on the right.
// RL9 - Shift with subtract places the upper word into product high.
// RL10 - Shift with subtract subtracts product low from destination and stores it.
// RL11 - Shift with subtract passes shifted-out bits to the following accumulator.
// RL12 - Shift with subtract sets flags, and tag when source is memory.
// RL13 - Plus-second-register addressing adds the step to the pointer after access.
// RL14 - Post-increment addressing advances the pointer by two per word.
// RL15 - String shift with add adds product low into the destination string.
// RL16 - Pre-increment moves the pointer before using the new accumulator.
// RL17 - Memory form may take a second word as direct address.
// RL18 - Program counter advances by one at completion unless repeat holds it.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "datapath_cfg.svh"

module shift_left_product_datapath
    import datapath_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    state_t state_r;
    command_t cmd_r;
    flags_t flags_r;
    logic [3:0] shiftVal_r;
    logic [3:0] strLen_r;
    logic [3:0] accPtr_r;
    logic [3:0] repeatCnt_r;
    logic [3:0] iterLeft_r;
    logic xm_r;
    logic [15:0] productHigh_r;
    logic [15:0] addrPtr_r;
    logic [15:0] addrStep_r;
    logic [15:0] operand2_r;
    logic [15:0] pc_r;
    logic [15:0] workAddr_r;
    logic [15:0] carry_r;
    logic [4:0] words_r;
    logic [4:0] idx_r;
    logic chain_r;
    logic zeroAcc_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [15:0] acc_r [16];
    logic [16:0] mem_r [16];

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic busy;
    logic hit;
    logic badAccess;
    logic wrEn;
    logic startCmd;
    logic [31:0] rdData;
    command_t newCmd;

    assign busy = (state_r != ST_IDLE);
    assign pready = psel & penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign newCmd = command_t'(pwdata[15:0]);

    always_comb begin
        rdData = 32'h0000_0000;
        hit = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (paddr[7:6] == `REGION_ACC) begin
            rdData = {16'h0000, acc_r[paddr[5:2]]};
        end else if (paddr[7:6] == `REGION_MEM) begin
            rdData = {15'h0000, mem_r[paddr[5:2]]};
        end else begin
            case (paddr)
                `OFF_CMD: rdData = {16'h0000, cmd_r};
                `OFF_SHIFT: rdData = {28'h000_0000, shiftVal_r};
                `OFF_STATUS: begin
                    rdData[`ST_XM_BIT] = xm_r;
                    rdData[`ST_OF_BIT] = flags_r.overflowFlag;
                    rdData[`ST_SF_BIT] = flags_r.signFlag;
                    rdData[`ST_ZF_BIT] = flags_r.zeroFlag;
                    rdData[`ST_CF_BIT] = flags_r.carryFlag;
                    rdData[`ST_TAG_BIT] = flags_r.tag;
                    rdData[`ST_BUSY_BIT] = busy;
                end
                `OFF_PRODHI: rdData = {16'h0000, productHigh_r};
                `OFF_STRLEN: rdData = {28'h000_0000, strLen_r};
                `OFF_ADDRPTR: rdData = {16'h0000, addrPtr_r};
                `OFF_ADDRSTEP: rdData = {16'h0000, addrStep_r};
                `OFF_OPERAND2: rdData = {16'h0000, operand2_r};
                `OFF_PC: rdData = {16'h0000, pc_r};
                `OFF_ACCPTR: rdData = {28'h000_0000, accPtr_r};
                `OFF_REPEAT: rdData = {28'h000_0000, repeatCnt_r};
                default: hit = 1'b0;
            endcase
        end
    end

    // Writes during an instruction are refused so that software never races the datapath.
    assign badAccess = ~hit | (pwrite & busy) | (pwrite & (paddr == `OFF_PRODHI));
    assign wrEn = psel & penable & pwrite & ~badAccess;
    assign startCmd = wrEn & (paddr == `OFF_CMD);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel & ~penable) begin
            prdata_r <= badAccess ? 32'h0000_0000 : rdData;
            pslverr_r <= badAccess;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shiftVal_r <= `RST_NIBBLE;
            strLen_r <= `RST_NIBBLE;
            repeatCnt_r <= `RST_NIBBLE;
            xm_r <= 1'b0;
            addrStep_r <= `RST_WORD16;
            operand2_r <= `RST_WORD16;
        end else if (wrEn) begin
            case (paddr)
                `OFF_SHIFT: shiftVal_r <= pwdata[3:0];
                `OFF_STRLEN: strLen_r <= pwdata[3:0];
                `OFF_REPEAT: repeatCnt_r <= pwdata[3:0];
                `OFF_STATUS: xm_r <= pwdata[`ST_XM_BIT];
                `OFF_ADDRSTEP: addrStep_r <= pwdata[15:0];
                `OFF_OPERAND2: operand2_r <= pwdata[15:0];
                default: xm_r <= xm_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    logic [3:0] srcIdx;
    logic [3:0] dstIdx;
    logic [3:0] memIdx;
    logic [15:0] srcWord;
    logic [15:0] dstWord;
    logic [15:0] lowWord;
    logic [15:0] carryOut;
    logic [15:0] resWord;
    logic [16:0] sum17;
    logic [16:0] diff17;
    logic resCarry;
    logic resOvf;
    logic isLast;
    logic isAdd;
    logic running;

    assign running = (state_r == ST_RUN);
    assign isAdd = (cmd_r.op == OP_STR_ADD_LOW);
    assign srcIdx = accPtr_r + (cmd_r.srcOffset ? `ACC_OFFSET : 4'h0) + idx_r[3:0];
    assign dstIdx = accPtr_r + (cmd_r.dstOffset ? `ACC_OFFSET : 4'h0) + idx_r[3:0];
    assign memIdx = workAddr_r[4:1];
    assign srcWord = cmd_r.srcMemory ? mem_r[memIdx][15:0] : acc_r[srcIdx];
    assign dstWord = acc_r[dstIdx];
    assign isLast = (idx_r == words_r - 5'h01);

    // RL1 shift by value
    // RL2 sign fill on top word
    shift_word_unit shift_word_unit_i (
        .wordIn(srcWord),
        .carryIn(carry_r),
        .shiftAmt(shiftVal_r),
        .signFill(xm_r & isLast),
        .lowOut(lowWord),
        .carryOut(carryOut)
    );

    // RL10 subtract product low
    assign diff17 = {1'b0, dstWord} - {1'b0, lowWord} - {16'h0000, chain_r};
    // RL15 add product low
    assign sum17 = {1'b0, dstWord} + {1'b0, lowWord} + {16'h0000, chain_r};
    assign resWord = isAdd ? sum17[15:0] : diff17[15:0];
    assign resCarry = isAdd ? sum17[16] : diff17[16];
    assign resOvf = isAdd ? ((dstWord[15] == lowWord[15]) && (resWord[15] != dstWord[15]))
                          : ((dstWord[15] != lowWord[15]) && (resWord[15] != dstWord[15]));

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (startCmd) state_r <= ST_PREP;
                ST_PREP: state_r <= ST_RUN;
                ST_RUN: if (isLast) state_r <= ST_DONE;
                ST_DONE: state_r <= (iterLeft_r != 4'h0) ? ST_PREP : ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_r <= '0;
            words_r <= 5'h00;
            iterLeft_r <= `RST_NIBBLE;
        end else if (startCmd) begin
            cmd_r <= newCmd;
            // RL5 repeat lengthens string
            if (newCmd.op == OP_SUB_LOW) begin
                words_r <= 5'h01;
            end else begin
                words_r <= {1'b0, strLen_r} +
                           (newCmd.repeatPrefix ? `STR_EXTRA_REPEAT : `STR_EXTRA_NORMAL);
            end
            iterLeft_r <= (newCmd.op == OP_SUB_LOW && newCmd.repeatPrefix) ? repeatCnt_r
                                                                             : `RST_NIBBLE;
        end else if (state_r == ST_DONE && iterLeft_r != 4'h0) begin
            iterLeft_r <= iterLeft_r - 4'h1;
        end
    end

    // The pointer moves in the cycle before the first word is read, never during the shift.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            accPtr_r <= `RST_NIBBLE;
        end else if (wrEn && paddr == `OFF_ACCPTR) begin
            accPtr_r <= pwdata[3:0];
        end else if (state_r == ST_PREP) begin
            // RL7 pre-modify pointer first
            if (cmd_r.modifier == MOD_PRE_INC) begin
                // RL16 pre-increment pointer
                accPtr_r <= accPtr_r + 4'h1;
            end else if (cmd_r.modifier == MOD_PRE_DEC) begin
                accPtr_r <= accPtr_r - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            idx_r <= 5'h00;
            carry_r <= `RST_WORD16;
            chain_r <= 1'b0;
            zeroAcc_r <= 1'b1;
        end else if (state_r == ST_PREP) begin
            idx_r <= 5'h00;
            carry_r <= `RST_WORD16;
            chain_r <= 1'b0;
            zeroAcc_r <= 1'b1;
        end else if (running) begin
            // RL11 shifted bits to next word
            idx_r <= idx_r + 5'h01;
            carry_r <= carryOut;
            chain_r <= resCarry;
            zeroAcc_r <= zeroAcc_r &
                ((cmd_r.op == OP_TO_PRODUCT) ? (lowWord == 16'h0000) : (resWord == 16'h0000));
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            workAddr_r <= `RST_WORD16;
        end else if (state_r == ST_PREP) begin
            // RL17 second word as address
            workAddr_r <= (cmd_r.addrMode == ADR_DIRECT) ? operand2_r : addrPtr_r;
        end else if (running && cmd_r.srcMemory) begin
            // RL13 add step after access
            // RL14 advance by two
            workAddr_r <= workAddr_r +
                ((cmd_r.addrMode == ADR_PLUS_STEP) ? addrStep_r : `ADDR_POST_INC);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            addrPtr_r <= `RST_WORD16;
        end else if (wrEn && paddr == `OFF_ADDRPTR) begin
            addrPtr_r <= pwdata[15:0];
        end else if (state_r == ST_DONE && cmd_r.srcMemory &&
                     (cmd_r.addrMode == ADR_POST_INC || cmd_r.addrMode == ADR_PLUS_STEP)) begin
            // RL13 pointer write-back
            addrPtr_r <= workAddr_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            productHigh_r <= `RST_WORD16;
        end else if (running && isLast) begin
            // RL3 upper word latched
            // RL9 upper word latched
            productHigh_r <= carryOut;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags_r <= '0;
        end else if (running && isLast) begin
            if (cmd_r.op == OP_TO_PRODUCT) begin
                // RL6 product flags
                flags_r.overflowFlag <= 1'b0;
                flags_r.signFlag <= carryOut[15];
                flags_r.zeroFlag <= zeroAcc_r & (lowWord == 16'h0000) & (carryOut == 16'h0000);
                flags_r.carryFlag <= 1'b0;
            end else begin
                // RL12 arithmetic flags
                flags_r.overflowFlag <= resOvf;
                flags_r.signFlag <= resWord[15];
                flags_r.zeroFlag <= zeroAcc_r & (resWord == 16'h0000);
                flags_r.carryFlag <= resCarry;
            end
            // RL12 memory tag
            if (cmd_r.srcMemory) begin
                flags_r.tag <= mem_r[memIdx][16];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc_r <= `RST_WORD16;
        end else if (wrEn && paddr == `OFF_PC) begin
            pc_r <= pwdata[15:0];
        end else if (state_r == ST_DONE && iterLeft_r == 4'h0) begin
            // RL18 advance one word
            pc_r <= pc_r + 16'h0001;
        end
    end

    // Accumulators are written over APB and by arithmetic forms; the product form never touches them.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                acc_r[i] <= `RST_WORD16;
            end
        end else if (wrEn && paddr[7:6] == `REGION_ACC) begin
            acc_r[paddr[5:2]] <= pwdata[15:0];
        end else if (running && cmd_r.op != OP_TO_PRODUCT) begin
            // RL4 product form skips writes
            acc_r[dstIdx] <= resWord;
            if (cmd_r.op == OP_SUB_LOW && isLast) begin
                // RL11 shifted bits to following
                acc_r[dstIdx + 4'h1] <= carryOut;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= `RST_WORD17;
            end
        end else if (wrEn && paddr[7:6] == `REGION_MEM) begin
            mem_r[paddr[5:2]] <= pwdata[16:0];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence seqAccept;
        state_r == ST_IDLE && startCmd;
    endsequence

    sequence seqPrepRun;
        state_r == ST_PREP ##1 state_r == ST_RUN;
    endsequence

    chk_start_order: // RL7
        assert property (seqAccept |=> seqPrepRun) else $error("Pointer step not before shift.");
    chk_premod_inc: // RL16
        assert property (state_r == ST_PREP && cmd_r.modifier == MOD_PRE_INC
            |=> accPtr_r == $past(accPtr_r) + 4'h1) else $error("Pre-increment missing.");
    chk_ph_latch: // RL3
        assert property (running && isLast |=> productHigh_r == $past(carryOut))
            else $error("Product high not latched.");
    chk_next_acc_ph: // RL11
        assert property (running && isLast && cmd_r.op == OP_SUB_LOW
            |=> acc_r[$past(dstIdx) + 4'h1] == productHigh_r) else $error("Shifted bits lost.");
    chk_acc_kept: // RL4
        assert property (running && cmd_r.op == OP_TO_PRODUCT && !cmd_r.srcMemory
            |=> acc_r[$past(srcIdx)] == $past(srcWord)) else $error("Source accumulator changed.");
    chk_sub_write: // RL10
        assert property (running && cmd_r.op == OP_SUB_LOW
            |=> acc_r[$past(dstIdx)] == $past(dstWord) - $past(lowWord))
            else $error("Difference not stored.");
    chk_add_write: // RL15
        assert property (running && isAdd && idx_r == 5'h00
            |=> acc_r[$past(dstIdx)] == $past(dstWord) + $past(lowWord))
            else $error("Sum not stored.");
    chk_zero_right: // RL8
        assert property (running && idx_r == 5'h00
            |-> (lowWord & ((16'h0001 << shiftVal_r) - 16'h0001)) == 16'h0000)
            else $error("Right side not zero filled.");
    chk_sign_fill: // RL2
        assert property (running && isLast && xm_r && srcWord[15] |=> productHigh_r[15])
            else $error("Sign not extended.");
    chk_post_inc: // RL14
        assert property (running && cmd_r.srcMemory && cmd_r.addrMode == ADR_POST_INC
            |=> workAddr_r == $past(workAddr_r) + 16'h0002) else $error("Pointer not plus two.");
    chk_step_add: // RL13
        assert property (running && cmd_r.srcMemory && cmd_r.addrMode == ADR_PLUS_STEP
            |=> workAddr_r == $past(workAddr_r) + addrStep_r) else $error("Step not added.");
    chk_direct_addr: // RL17
        assert property (state_r == ST_PREP && cmd_r.addrMode == ADR_DIRECT
            |=> workAddr_r == operand2_r) else $error("Direct address not used.");
    chk_repeat_len: // RL5
        assert property (seqAccept ##0 (newCmd.op != OP_SUB_LOW && newCmd.repeatPrefix)
            |=> words_r == {1'b0, $past(strLen_r)} + 5'h02) else $error("Repeat length wrong.");
    chk_string_len: // RL1
        assert property (seqAccept ##0 (newCmd.op != OP_SUB_LOW && !newCmd.repeatPrefix)
            |=> words_r == {1'b0, $past(strLen_r)} + 5'h01) else $error("String length wrong.");
    chk_sign_flag: // RL6
        assert property (running && isLast && cmd_r.op == OP_TO_PRODUCT
            |=> flags_r.signFlag == productHigh_r[15]) else $error("Sign flag wrong.");
    chk_tag_copy: // RL12
        assert property (running && isLast && cmd_r.srcMemory
            |=> flags_r.tag == mem_r[$past(memIdx)][16]) else $error("Tag flag wrong.");
    chk_pc_step: // RL18
        assert property (state_r == ST_DONE && iterLeft_r == 4'h0
            |=> pc_r == $past(pc_r) + 16'h0001) else $error("Program counter not advanced.");
    chk_pc_hold: // RL18
        assert property (state_r == ST_DONE && iterLeft_r != 4'h0 |=> pc_r == $past(pc_r))
            else $error("Program counter moved during repeat.");
endmodule

// [shift_left_product_datapath_test.sv]
// Self-checking bench for the shift-left product datapath.
`timescale 1ns/100ps
`include "datapath_cfg.svh"

module shift_left_product_datapath_test
    import datapath_pkg::*;
;
    typedef struct packed {
        addr_mode_t mode;
        logic [15:0] start;
        logic [15:0] ptr;
    } row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int tests_run = 0;
    row_t rows [4] = '{'{ADR_INDIRECT, 16'h0004, 16'h0004}, '{ADR_POST_INC, 16'h0004, 16'h0006},
        '{ADR_PLUS_STEP, 16'h0004, 16'h000A}, '{ADR_DIRECT, 16'h0000, 16'h0000}};
    logic [15:0] ph [4] = '{16'h0008, 16'hFFF8, 16'h0000, 16'h0000};

    shift_left_product_datapath shift_left_product_datapath_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // The release is followed by an idle edge so no signal is driven twice in one step.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        cmp(nm, e, rd & m);
    endtask

    function automatic command_t cmd(opcode_t op, logic mem, logic dsto, ptr_mod_t md,
        addr_mode_t am, logic rp);
        cmd = '{6'h00, rp, am, md, dsto, 1'b0, mem, op};
    endfunction

    // Polls busy until it falls; only the watchdog bounds it, as the run length varies.
    task automatic run(input command_t c);
        wr(`OFF_CMD, {16'h0000, c});
        rd = 32'h0000_0100;
        while (rd[`ST_BUSY_BIT] !== 1'b0) begin
            xfer(1'b0, `OFF_STATUS, 32'h0000_0000);
        end
    endtask

    task automatic end_of_test();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk("status", `OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`OFF_SHIFT, 32'h0000_0004);
        wr(8'h88, 32'h0001_0010);
        wr(`OFF_ADDRSTEP, 32'h0000_0006);
        wr(`OFF_OPERAND2, 32'h0000_0004);
        foreach (rows[i]) begin
            wr(`OFF_ADDRPTR, {16'h0000, rows[i].start});
            wr(8'h40, 32'h0000_0200);
            run(cmd(OP_SUB_LOW, 1'b1, 1'b0, MOD_NONE, rows[i].mode, 1'b0));
            rdchk("pointer", `OFF_ADDRPTR, 32'h0000_FFFF, {16'h0000, rows[i].ptr});
            rdchk("difference", 8'h40, 32'h0000_FFFF, 32'h0000_0100);
            rdchk("tag", `OFF_STATUS, 32'h0000_0020, 32'h0000_0020);
            rdchk("pc", `OFF_PC, 32'h0000_FFFF, 32'(i + 1));
        end
        wr(`OFF_ACCPTR, 32'h0000_0002);
        wr(8'h4C, 32'h0000_1234);
        wr(8'h6C, 32'h0000_5000);
        run(cmd(OP_SUB_LOW, 1'b0, 1'b1, MOD_PRE_INC, ADR_INDIRECT, 1'b0));
        rdchk("acc pointer", `OFF_ACCPTR, 32'h0000_000F, 32'h0000_0003);
        rdchk("product high", `OFF_PRODHI, 32'h0000_FFFF, 32'h0000_0001);
        rdchk("dest", 8'h6C, 32'h0000_FFFF, 32'h0000_2CC0);
        rdchk("next acc", 8'h70, 32'h0000_FFFF, 32'h0000_0001);
        rdchk("flags", `OFF_STATUS, 32'h0000_001E, 32'h0000_0000);
        wr(`OFF_ACCPTR, 32'h0000_0000);
        wr(`OFF_STRLEN, 32'h0000_0001);
        wr(8'h40, 32'h0000_8001);
        wr(8'h44, 32'h0000_8123);
        wr(8'h48, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(`OFF_STATUS, {31'h0, k[0]});
            run(cmd(OP_TO_PRODUCT, 1'b0, 1'b0, MOD_NONE, ADR_INDIRECT, k[1]));
            rdchk("string product", `OFF_PRODHI, 32'h0000_FFFF, {16'h0, ph[k]});
            rdchk("source", 8'h44, 32'h0000_FFFF, 32'h0000_8123);
            rdchk("string flags", `OFF_STATUS, 32'h0000_001F, {29'h0,ph[k][15],1'b0,k[0]});
        end
        wr(`OFF_STATUS, 32'h0000_0000);
        wr(`OFF_STRLEN, 32'h0000_0000);
        wr(8'h40, 32'h0000_0003);
        wr(8'h60, 32'h0000_0010);
        run(cmd(OP_STR_ADD_LOW, 1'b0, 1'b1, MOD_NONE, ADR_INDIRECT, 1'b0));
        rdchk("string sum", 8'h60, 32'h0000_FFFF, 32'h0000_0040);
        wr(`OFF_PRODHI, 32'h0000_1111);
        cmp("read-only error", 32'h0000_0001, {31'h0, er});
        rdchk("unmapped", 8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
        cmp("unmapped error", 32'h0000_0001, {31'h0, er});
        wr(`OFF_ACCPTR, 32'h0000_0002);
        wr(`OFF_REPEAT, 32'h0000_0001);
        wr(`OFF_PC, 32'h0000_0000);
        run(cmd(OP_SUB_LOW, 1'b0, 1'b1, MOD_PRE_DEC, ADR_INDIRECT, 1'b1));
        rdchk("repeat dest", 8'h60, 32'h0000_FFFF, 32'h0000_0010);
        rdchk("repeat next", 8'h68, 32'h0000_FFFF, 32'h0000_0008);
        rdchk("repeat pc", `OFF_PC, 32'h0000_FFFF, 32'h0000_0001);
        rdchk("pre-decrement", `OFF_ACCPTR, 32'h0000_000F, 32'h0000_0000);
        run(cmd(OP_STR_SUB_LOW, 1'b0, 1'b1, MOD_NONE, ADR_INDIRECT, 1'b0));
        rdchk("string difference", 8'h60, 32'h0000_FFFF, 32'h0000_FFE0);
        rdchk("string borrow", `OFF_STATUS, 32'h0000_001E, 32'h0000_0014);
        wr(`OFF_CMD, {16'h0000, cmd(OP_TO_PRODUCT, 1'b0, 1'b0, MOD_NONE, ADR_INDIRECT, 1'b0)});
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk("reset status", `OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk("reset pc", `OFF_PC, 32'h0000_FFFF, 32'h0000_0000);
        end_of_test();
    end
endmodule
